/* File: remote_uart_model.sv */
// Remote serial port model: sends characters into the block and collects what it transmits.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module remote_uart_model
  import uart_flow_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic rxReadyN,
  input wire logic obeyReady,
  input wire logic stall,
  output logic rxCharValid,
  input wire logic rxCharReady,
  output logic [CHAR_W-1:0] rxCharData,
  output logic [ERR_W-1:0] rxCharError,
  input wire logic txCharValid,
  output logic txCharReady,
  input wire logic [CHAR_W-1:0] txCharData
);
  logic [CHAR_W-1:0] seen[$];
  logic slowTick = 1'b0;

  initial
  begin
    rxCharValid = 1'b0;
    rxCharData = 8'h00;
    rxCharError = 4'h0;
  end

  // A stalled shifter takes a character only every other cycle.
  assign txCharReady = reset_n && !(stall && slowTick);

  always @(posedge sys_clk)
  begin
    slowTick <= !slowTick;
    if (txCharValid && txCharReady)
      seen.push_back(txCharData);
  end

  task automatic sendChar(input logic [CHAR_W-1:0] d, input logic [ERR_W-1:0] e, output bit ok);
    int n;
    n = 0;
    // While obeyReady is set, no new character is started for up to 200 cycles while the block's ready pin is released.
    while (obeyReady && rxReadyN && n < 200)
    begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    rxCharValid = 1'b1;
    rxCharData = d;
    rxCharError = e;
    while (!rxCharReady && n < 400)
    begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    @(posedge sys_clk);
    #2;
    ok = (n < 400);
    // Released lines carry the inverse so stale data is never mistaken for a character.
    rxCharValid = 1'b0;
    rxCharData = ~d;
    rxCharError = ~e;
    @(posedge sys_clk);
    #2;
  endtask : sendChar
endmodule : remote_uart_model

`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the serial-port flow-control block.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tb_top
  import uart_flow_pkg::*;
;
  localparam logic [7:0] PA = 8'h13;
  localparam logic [7:0] PB = 8'h93;
  localparam logic [7:0] RA = 8'h11;
  localparam logic [7:0] RB = 8'h91;
  logic sys_clk = 1'b0, reset_n = 1'b0, portEnable = 1'b1, obeyReady = 1'b0, stall = 1'b0;
  logic rxReadyFlowEnable = 1'b0, txPermitFlowEnable = 1'b0, softFlowEnable = 1'b0;
  logic [1:0] softRxFlowMode = 2'h0, softTxFlowMode = 2'h0;
  logic resumeOnAnyChar = 1'b0, specialCharDetect = 1'b0, rxReadReady = 1'b0;
  logic [4:0] rxTriggerLevel = 5'h04;
  logic txPermitN = 1'b0, txQueueValid = 1'b0;
  logic [7:0] txQueueData = 8'h00;
  logic [5:0] irqSourceSet = 6'h00, irqClear = 6'h00, irqMask = 6'h02;
  logic rxCharValid, rxCharReady, rxReadValid, rxReadyN, txQueueReady, txCharValid, txCharReady;
  logic remoteTxHalted, txPausedByRemote, irqOut;
  logic [7:0] rxCharData, rxReadData, txCharData;
  logic [3:0] rxCharError;
  logic [4:0] rxLevel;
  logic [5:0] rawIrqStatus, maskedIrqStatus;
  int errCount = 0, totalChecks = 0;

  uart_flow_control #(.FIFO_DEPTH(16)) DUT (.sys_clk, .reset_n, .portEnable, .rxReadyFlowEnable,
    .txPermitFlowEnable, .softFlowEnable, .softRxFlowMode, .softTxFlowMode, .resumeOnAnyChar,
    .specialCharDetect, .pauseCharA(PA), .pauseCharB(PB), .resumeCharA(RA), .resumeCharB(RB),
    .rxTriggerLevel, .rxCharValid, .rxCharReady, .rxCharData, .rxCharError, .rxReadValid,
    .rxReadReady, .rxReadData, .rxReadError(), .rxLevel, .rxReadyN, .txPermitN, .txQueueValid,
    .txQueueReady, .txQueueData, .txCharValid, .txCharReady, .txCharData, .remoteTxHalted,
    .txPausedByRemote, .irqSourceSet, .irqClear, .irqMask, .rawIrqStatus, .maskedIrqStatus,
    .irqOut);

  remote_uart_model remote (.sys_clk, .reset_n, .rxReadyN, .obeyReady, .stall, .rxCharValid,
    .rxCharReady, .rxCharData, .rxCharError, .txCharValid, .txCharReady, .txCharData);

  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic endOfTest;
    $display("checks %0d, mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : endOfTest

  task automatic giveUp;
    errCount++;
    endOfTest();
  endtask : giveUp

  task automatic tick(input int n = 1);
    repeat (n)
    begin
      @(posedge sys_clk);
      #2;
    end
  endtask : tick

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic send(input logic [7:0] d, input logic [3:0] e);
    bit ok;
    remote.sendChar(d, e, ok);
    if (!ok)
      giveUp();
  endtask : send

  task automatic readChar(input logic [7:0] exp);
    int n;
    n = 0;
    while (rxReadValid !== 1'b1)
    begin
      tick();
      n++;
      if (n > 100)
        giveUp();
    end
    chk(rxReadData, exp);
    rxReadReady = 1'b1;
    tick();
    rxReadReady = 1'b0;
    tick();
  endtask : readChar

  task automatic waitTake;
    int n;
    n = 0;
    while (txQueueReady !== 1'b1)
    begin
      tick();
      n++;
      if (n > 100)
        giveUp();
    end
    tick();
    txQueueValid = 1'b0;
    tick();
  endtask : waitTake

  task automatic expectTx(input logic [7:0] exp);
    int n;
    n = 0;
    while (remote.seen.size() == 0)
    begin
      tick();
      n++;
      if (n > 200)
        giveUp();
    end
    chk(remote.seen.pop_front(), exp);
  endtask : expectTx

  ////////////////////////////////////////////////////////////////////////////////
  task automatic testReady;
    rxReadyFlowEnable = 1'b1;
    obeyReady = 1'b1;
    tick(3);
    chk(rxReadyN, 1'b0);
    for (int i = 0; i < 4; i++)
      send(8'h20 + i[7:0], 4'h0);
    tick(2);
    chk(rxReadyN, 1'b1);
    chk(rxLevel, 5'h04);
    readChar(8'h20);
    tick(2);
    chk(rxReadyN, 1'b0);
    for (int i = 1; i < 4; i++)
      readChar(8'h20 + i[7:0]);
    rxReadyFlowEnable = 1'b0;
    obeyReady = 1'b0;
    for (int i = 0; i < 16; i++)
      send(8'h40 + i[7:0], 4'h0);
    chk(rxLevel, 5'h10);
    chk(rxCharReady, 1'b0);
    for (int i = 0; i < 16; i++)
      readChar(8'h40 + i[7:0]);
    portEnable = 1'b0;
    tick();
    chk(rxCharReady, 1'b0);
    chk(txQueueReady, 1'b0);
    portEnable = 1'b1;
    tick();
    $display("ready flow test done");
  endtask : testReady

  task automatic testPermit;
    txPermitFlowEnable = 1'b1;
    txPermitN = 1'b1;
    tick(4);
    txQueueData = 8'h5a;
    txQueueValid = 1'b1;
    tick(6);
    chk(txQueueReady, 1'b0);
    chk(txCharValid, 1'b0);
    txPermitN = 1'b0;
    waitTake();
    txPermitN = 1'b1;
    expectTx(8'h5a);
    tick(4);
    txQueueData = 8'h66;
    txQueueValid = 1'b1;
    tick(4);
    chk(txQueueReady, 1'b0);
    chk(txCharValid, 1'b0);
    txPermitN = 1'b0;
    waitTake();
    expectTx(8'h66);
    txPermitFlowEnable = 1'b0;
    txPermitN = 1'b1;
    tick(4);
    txQueueData = 8'ha5;
    txQueueValid = 1'b1;
    waitTake();
    expectTx(8'ha5);
    txPermitN = 1'b0;
    $display("permit flow test done");
  endtask : testPermit

  task automatic testPause;
    softFlowEnable = 1'b1;
    send(PA, 4'h0);
    readChar(PA);
    for (int m = 1; m < 4; m++)
    begin
      softRxFlowMode = m[1:0];
      tick();
      if (m != 2)
        send(PA, 4'hf);
      if (m != 1)
        send(PB, 4'h0);
      chk(rawIrqStatus[IRQ_PAUSE], 1'b1);
      chk(irqOut, 1'b1);
      chk(txPausedByRemote, 1'b1);
      chk(rxLevel, 5'h00);
      send(m == 2 ? RB : RA, 4'h0);
      chk(rawIrqStatus[IRQ_PAUSE], 1'b0);
      chk(txPausedByRemote, 1'b0);
    end
    send(PA, 4'h0);
    send(8'h55, 4'h0);
    chk(txPausedByRemote, 1'b0);
    rxReadReady = 1'b1;
    tick(4);
    rxReadReady = 1'b0;
    softRxFlowMode = MODE_PAIR_A;
    resumeOnAnyChar = 1'b1;
    send(PA, 4'h0);
    chk(txPausedByRemote, 1'b1);
    send(8'h41, 4'h0);
    chk(txPausedByRemote, 1'b0);
    readChar(PA);
    readChar(8'h41);
    resumeOnAnyChar = 1'b0;
    softFlowEnable = 1'b0;
    specialCharDetect = 1'b1;
    irqMask = 6'h00;
    send(PB, 4'h2);
    chk(rawIrqStatus[IRQ_PAUSE], 1'b1);
    chk(irqOut, 1'b0);
    chk(txPausedByRemote, 1'b0);
    readChar(PB);
    irqClear = 6'h02;
    tick();
    irqClear = 6'h00;
    tick();
    chk(rawIrqStatus[IRQ_PAUSE], 1'b0);
    specialCharDetect = 1'b0;
    irqMask = 6'h02;
    softRxFlowMode = MODE_NONE;
    $display("pause match test done");
  endtask : testPause

  task automatic testInsert;
    rxTriggerLevel = 5'h02;
    softFlowEnable = 1'b1;
    stall = 1'b1;
    for (int m = 1; m < 4; m++)
    begin
      softTxFlowMode = m[1:0];
      send(8'h60, 4'h0);
      send(8'h61, 4'h0);
      if (m != 2)
        expectTx(PA);
      if (m != 1)
        expectTx(PB);
      tick();
      chk(remoteTxHalted, 1'b1);
      readChar(8'h60);
      readChar(8'h61);
      if (m != 2)
        expectTx(RA);
      if (m != 1)
        expectTx(RB);
      tick();
      chk(remoteTxHalted, 1'b0);
    end
    softTxFlowMode = MODE_PAIR_A;
    send(8'h62, 4'h0);
    send(8'h63, 4'h0);
    expectTx(PA);
    softFlowEnable = 1'b0;
    expectTx(RA);
    tick();
    chk(remoteTxHalted, 1'b0);
    readChar(8'h62);
    readChar(8'h63);
    stall = 1'b0;
    $display("insert test done");
  endtask : testInsert

  task automatic testIrq;
    irqMask = 6'h21;
    irqSourceSet = 6'h3d;
    tick();
    irqSourceSet = 6'h00;
    tick();
    chk(rawIrqStatus, 6'h3d);
    chk(maskedIrqStatus, 6'h21);
    chk(irqOut, 1'b1);
    irqSourceSet = 6'h01;
    irqClear = 6'h3d;
    tick();
    irqSourceSet = 6'h00;
    irqClear = 6'h00;
    tick();
    chk(rawIrqStatus, 6'h01);
    irqMask = 6'h1e;
    tick();
    chk(irqOut, 1'b0);
    irqClear = 6'h01;
    tick();
    irqClear = 6'h00;
    chk(rawIrqStatus, 6'h00);
    chk(maskedIrqStatus, 6'h00);
    irqMask = 6'h02;
    $display("interrupt test done");
  endtask : testIrq

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge sys_clk);
    #2;
    reset_n = 1'b1;
    tick();
    testReady();
    testPermit();
    testPause();
    testInsert();
    testIrq();
    endOfTest();
  end
endmodule : tb_top

`default_nettype wire

/* File: uart_flow_control.sv */
// Receive queue and flow-control logic of the serial port.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module flow_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int CNT_W = 5
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [CNT_W-1:0] level
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_reg;
  logic [PTR_W-1:0] rdPtr_reg;
  logic [CNT_W-1:0] count_reg;
  logic doWrite;
  logic doRead;

  assign inReady = (count_reg != CNT_W'(DEPTH));
  assign outValid = (count_reg != '0);
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign outData = mem[rdPtr_reg];
  assign level = count_reg;

  always_ff @(posedge sys_clk)
  begin
    if (doWrite)
    begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (doWrite)
      begin
        wrPtr_reg <= (wrPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doRead)
      begin
        rdPtr_reg <= (rdPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      if (doWrite && !doRead)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (doRead && !doWrite)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : flow_fifo

////////////////////////////////////////////////////////////////////////////////
module uart_flow_control
  import uart_flow_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic portEnable,
  input wire logic rxReadyFlowEnable,
  input wire logic txPermitFlowEnable,
  input wire logic softFlowEnable,
  input wire logic [1:0] softRxFlowMode,
  input wire logic [1:0] softTxFlowMode,
  input wire logic resumeOnAnyChar,
  input wire logic specialCharDetect,
  input wire logic [CHAR_W-1:0] pauseCharA,
  input wire logic [CHAR_W-1:0] pauseCharB,
  input wire logic [CHAR_W-1:0] resumeCharA,
  input wire logic [CHAR_W-1:0] resumeCharB,
  input wire logic [LEVEL_W-1:0] rxTriggerLevel,
  input wire logic rxCharValid,
  output logic rxCharReady,
  input wire logic [CHAR_W-1:0] rxCharData,
  input wire logic [ERR_W-1:0] rxCharError,
  output logic rxReadValid,
  input wire logic rxReadReady,
  output logic [CHAR_W-1:0] rxReadData,
  output logic [ERR_W-1:0] rxReadError,
  output logic [LEVEL_W-1:0] rxLevel,
  output logic rxReadyN,
  input wire logic txPermitN,
  input wire logic txQueueValid,
  output logic txQueueReady,
  input wire logic [CHAR_W-1:0] txQueueData,
  output logic txCharValid,
  input wire logic txCharReady,
  output logic [CHAR_W-1:0] txCharData,
  output logic remoteTxHalted,
  output logic txPausedByRemote,
  input wire logic [IRQ_W-1:0] irqSourceSet,
  input wire logic [IRQ_W-1:0] irqClear,
  input wire logic [IRQ_W-1:0] irqMask,
  output logic [IRQ_W-1:0] rawIrqStatus,
  output logic [IRQ_W-1:0] maskedIrqStatus,
  output logic irqOut
);
  logic permitMeta_reg;
  logic permitSync_reg;
  logic rxReady_reg;
  logic pausedByXoff_reg;
  logic sawPauseA_reg;
  logic [IRQ_W-1:0] rawIrq_reg;
  logic remoteHalted_reg;
  logic sendPause_reg;
  insert_state_e insState_reg;
  logic [CHAR_W-1:0] txChar_reg;
  logic txCharValid_reg;
  logic rxFlowOn;
  logic specialOn;
  logic txFlowOn;
  logic rxTake;
  logic pauseHit;
  logic resumeHit;
  logic specialHit;
  logic storeChar;
  logic fifoInReady;
  logic [CHAR_W+ERR_W-1:0] fifoOut;
  logic wantPause;
  logic permitOk;
  logic txSlotFree;
  logic queueMayGo;
  logic insertFire;
  logic [CHAR_W-1:0] insertChar;

  ////////////////////////////////////////////////////////////////////////////////
  // The permit pin comes from the far side and is synchronised first.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      permitMeta_reg <= 1'b0;
      permitSync_reg <= 1'b0;
    end
    else
    begin
      permitMeta_reg <= !txPermitN;
      permitSync_reg <= permitMeta_reg;
    end
  end

  assign specialOn = specialCharDetect;
  assign rxFlowOn = softFlowEnable && !specialOn && (softRxFlowMode != MODE_NONE);
  assign txFlowOn = softFlowEnable && !specialOn && (softTxFlowMode != MODE_NONE);
  assign rxTake = rxCharValid && rxCharReady;

  ////////////////////////////////////////////////////////////////////////////////
  // Matching ignores rxCharError entirely.
  always_comb
  begin
    pauseHit = 1'b0;
    resumeHit = 1'b0;
    case (softRxFlowMode)
      MODE_PAIR_A:
      begin
        pauseHit = (rxCharData == pauseCharA);
        resumeHit = (rxCharData == resumeCharA);
      end
      MODE_PAIR_B:
      begin
        pauseHit = (rxCharData == pauseCharB);
        resumeHit = (rxCharData == resumeCharB);
      end
      MODE_BOTH:
      begin
        pauseHit = sawPauseA_reg && (rxCharData == pauseCharB);
        resumeHit = (rxCharData == resumeCharA) || (rxCharData == resumeCharB);
      end
      default:
      begin
        pauseHit = 1'b0;
        resumeHit = 1'b0;
      end
    endcase
    pauseHit = pauseHit && rxFlowOn;
    resumeHit = rxFlowOn && pausedByXoff_reg && (resumeHit || resumeOnAnyChar);
  end

  assign specialHit = specialOn && (rxCharData == pauseCharB);
  // Flow characters are dropped, except in resume-on-any and special modes.
  assign storeChar = !(rxFlowOn && !resumeOnAnyChar
                     && (pauseHit || resumeHit
                         || (softRxFlowMode == MODE_BOTH && rxCharData == pauseCharA)));

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      sawPauseA_reg <= 1'b0;
    end
    else if (rxTake)
    begin
      sawPauseA_reg <= (rxCharData == pauseCharA);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pausedByXoff_reg <= 1'b0;
    end
    else if (!rxFlowOn)
    begin
      pausedByXoff_reg <= 1'b0;
    end
    else if (rxTake && pauseHit)
    begin
      pausedByXoff_reg <= 1'b1;
    end
    else if (rxTake && resumeHit)
    begin
      pausedByXoff_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive queue; a full queue refuses the next character.
  assign rxCharReady = portEnable && fifoInReady;

  flow_fifo #(
    .WIDTH(CHAR_W + ERR_W),
    .DEPTH(FIFO_DEPTH),
    .CNT_W(LEVEL_W)
  ) rxQueue (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .inValid(rxCharValid && portEnable && storeChar),
    .inReady(fifoInReady),
    .inData({rxCharError, rxCharData}),
    .outValid(rxReadValid),
    .outReady(rxReadReady),
    .outData(fifoOut),
    .level(rxLevel)
  );

  assign rxReadData = fifoOut[CHAR_W-1:0];
  assign rxReadError = fifoOut[CHAR_W+ERR_W-1:CHAR_W];
  assign wantPause = (rxLevel >= rxTriggerLevel);

  // Ready output drops at the watermark and returns below it.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      rxReady_reg <= 1'b0;
    end
    else
    begin
      rxReady_reg <= rxReadyFlowEnable ? !wantPause : 1'b1;
    end
  end

  assign rxReadyN = !rxReady_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit gating: queued data starts only when every gate is open; inserted characters skip the pause gate.
  assign permitOk = !txPermitFlowEnable || permitSync_reg;
  assign txSlotFree = !txCharValid_reg || txCharReady;
  assign insertFire = portEnable && permitOk && txSlotFree && (insState_reg != INS_IDLE);
  assign queueMayGo = portEnable && permitOk && !pausedByXoff_reg && insState_reg == INS_IDLE;
  // Halted data stays queued; the shifter idles high with nothing offered.
  assign txQueueReady = queueMayGo && txSlotFree;
  assign txPausedByRemote = pausedByXoff_reg || (txPermitFlowEnable && !permitSync_reg);

  always_comb
  begin
    case (softTxFlowMode)
      MODE_PAIR_B: insertChar = sendPause_reg ? pauseCharB : resumeCharB;
      default:
      begin
        if (insState_reg == INS_SECOND)
        begin
          insertChar = sendPause_reg ? pauseCharB : resumeCharB;
        end
        else
        begin
          insertChar = sendPause_reg ? pauseCharA : resumeCharA;
        end
      end
    endcase
  end

  // Insertion sequencer for the automatic pause and resume characters.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      insState_reg <= INS_IDLE;
      sendPause_reg <= 1'b0;
      remoteHalted_reg <= 1'b0;
    end
    else
    begin
      case (insState_reg)
        INS_IDLE:
        begin
          if (txFlowOn && !remoteHalted_reg && wantPause)
          begin
            sendPause_reg <= 1'b1;
            insState_reg <= INS_FIRST;
          end
          else if (remoteHalted_reg && (!txFlowOn || !wantPause))
          begin
            sendPause_reg <= 1'b0;
            insState_reg <= INS_FIRST;
          end
        end
        INS_FIRST:
        begin
          if (insertFire)
          begin
            if (softTxFlowMode == MODE_BOTH)
            begin
              insState_reg <= INS_SECOND;
            end
            else
            begin
              insState_reg <= INS_IDLE;
              remoteHalted_reg <= sendPause_reg;
            end
          end
        end
        INS_SECOND:
        begin
          if (insertFire)
          begin
            insState_reg <= INS_IDLE;
            remoteHalted_reg <= sendPause_reg;
          end
        end
        default:
        begin
          insState_reg <= INS_IDLE;
        end
      endcase
    end
  end

  assign remoteTxHalted = remoteHalted_reg;

  // Inserted characters take the same path as data, so framing matches.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      txCharValid_reg <= 1'b0;
      txChar_reg <= '0;
    end
    else if (insertFire)
    begin
      txCharValid_reg <= 1'b1;
      txChar_reg <= insertChar;
    end
    else if (txQueueReady && txQueueValid)
    begin
      txCharValid_reg <= 1'b1;
      txChar_reg <= txQueueData;
    end
    else if (txCharReady)
    begin
      txCharValid_reg <= 1'b0;
    end
  end

  assign txCharValid = txCharValid_reg;
  assign txCharData = txChar_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky status; a set in the clear cycle wins. Resume match clears pause.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      rawIrq_reg <= IRQ_RESET;
    end
    else
    begin
      rawIrq_reg <= (rawIrq_reg & ~irqClear) | irqSourceSet;
      if (rxTake && (pauseHit || specialHit))
      begin
        rawIrq_reg[IRQ_PAUSE] <= 1'b1;
      end
      else if (rxTake && resumeHit)
      begin
        rawIrq_reg[IRQ_PAUSE] <= irqSourceSet[IRQ_PAUSE];
      end
    end
  end

  assign rawIrqStatus = rawIrq_reg;
  assign maskedIrqStatus = rawIrq_reg & irqMask;
  assign irqOut = |maskedIrqStatus;

  ////////////////////////////////////////////////////////////////////////////////
  AST_READY_WATERMARK: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rxReadyFlowEnable && (rxLevel >= rxTriggerLevel) |=> rxReadyN)
    else $error("ready stayed high at watermark");
  AST_READY_RETURN: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rxReadyFlowEnable && rxReadyN && (rxLevel < rxTriggerLevel) |=> !rxReadyN)
    else $error("ready not restored below watermark");
  AST_PERMIT_GATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    txQueueReady && txPermitFlowEnable |-> permitSync_reg)
    else $error("queue drained without permit");
  AST_FULL_REFUSE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rxLevel == LEVEL_W'(FIFO_DEPTH) |-> !rxCharReady)
    else $error("character accepted into full queue");
  AST_PAUSE_HALTS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rxTake && pauseHit |=> pausedByXoff_reg && rawIrqStatus[IRQ_PAUSE] && !txQueueReady)
    else $error("pause match did not halt");
  AST_RESUME_CLEARS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rxTake && resumeHit && !pauseHit |=> !pausedByXoff_reg)
    else $error("resume match did not release");
  AST_SPECIAL_NO_HALT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rxTake && specialHit |=> !pausedByXoff_reg && rawIrqStatus[IRQ_PAUSE] && (rxLevel != '0))
    else $error("special mode halted or dropped");
  AST_DISCARD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rxTake && pauseHit && !resumeOnAnyChar |=> $stable(rxLevel) || rxReadReady)
    else $error("pause character stored");
  AST_IRQ_LINE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rxTake && (pauseHit || specialHit) |=> irqOut || !irqMask[IRQ_PAUSE])
    else $error("interrupt line mismatch");
  AST_RESUME_SENT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    remoteHalted_reg && !txFlowOn && insState_reg == INS_IDLE |=> insState_reg == INS_FIRST)
    else $error("no resume after flow off");
  COV_PAUSE: cover property (@(posedge sys_clk) rxTake && pauseHit);
  COV_RESUME: cover property (@(posedge sys_clk) rxTake && resumeHit);
  COV_INSERT: cover property (@(posedge sys_clk) insertFire && sendPause_reg);
  COV_READY_DROP: cover property (@(posedge sys_clk) $fell(rxReady_reg));
endmodule : uart_flow_control

`default_nettype wire

/* File: uart_flow_pkg.sv */
// Constants shared by the serial-port flow-control block.
package uart_flow_pkg;
  localparam int CHAR_W = 8;
  localparam int ERR_W = 4;
  localparam int RX_FIFO_DEPTH = 16;
  localparam int LEVEL_W = 5;
  localparam int IRQ_W = 6;
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_PAIR_A = 2'h1;
  localparam logic [1:0] MODE_PAIR_B = 2'h2;
  localparam logic [1:0] MODE_BOTH = 2'h3;
  localparam int IRQ_TX_EMPTY = 0;
  localparam int IRQ_PAUSE = 1;
  localparam int IRQ_RX = 2;
  localparam int IRQ_TX = 3;
  localparam int IRQ_TIMEOUT = 4;
  localparam int IRQ_ERROR = 5;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 5'h00;
  typedef enum logic [1:0] {INS_IDLE, INS_FIRST, INS_SECOND} insert_state_e;
endpackage : uart_flow_pkg
